// ### hw/fsc_pkg.sv
// Shared constants and types for the flash erase and suspend controller
package fsc_pkg;

  // ==========================================================================
  // Clock and address layout
  localparam int unsigned CLK_MHZ    = 200;
  localparam int unsigned ADDR_W     = 24;
  localparam int unsigned SECT_LSB   = 16;
  localparam logic [2:0]  CMD_BYTES  = 3'h4;
  localparam logic [2:0]  OPC_BYTES  = 3'h1;
  localparam int unsigned TIMEOUT_MULT = 2;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_SSE    = 8'h20;
  localparam logic [7:0] OP_SE     = 8'hd8;
  localparam logic [7:0] OP_DIE    = 8'hc4;
  localparam logic [7:0] OP_PROG   = 8'h02;
  localparam logic [7:0] OP_SUSP   = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;

  // ==========================================================================
  // Flag status layout
  localparam logic [7:0]  FSR_RESET = 8'h80;
  localparam int unsigned FSR_RDY   = 7;
  localparam int unsigned FSR_ESUS  = 6;
  localparam int unsigned FSR_EERR  = 5;
  localparam int unsigned FSR_PERR  = 4;
  localparam int unsigned FSR_PSUS  = 2;
  localparam int unsigned FSR_PROT  = 1;
  localparam logic [1:0]  MAX_DEPTH = 2'h2;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {K_SSE = 2'h0, K_SE = 2'h1, K_DIE = 2'h2, K_PROG = 2'h3} fsc_kind_t;

  typedef struct packed {
    fsc_kind_t         kind;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       remain;
  } fsc_op_t;

  typedef struct packed {
    logic       byte_stb;
    logic [7:0] data;
    logic       frame_end;
    logic       aligned;
  } fsc_link_t;

  function automatic int unsigned us_to_cyc(input int unsigned us);
    return us * CLK_MHZ;
  endfunction

endpackage

// ### hw/fsc_link_rx.sv
// Serial link receiver: synchronises pins, shifts bytes, marks frame end
`timescale 1ns/100ps
module fsc_link_rx
  import fsc_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  input  wire logic i_ce,
  input  wire logic i_link_clk,
  input  wire logic i_cs_n,
  input  wire logic i_serial_io_lines,
  output fsc_link_t o_link
);

  // ==========================================================================
  // Two-stage synchronisers, bits are {link clock, chip select, data}
  localparam logic [2:0] PIN_IDLE = 3'h2;
  logic [2:0] meta;
  logic [2:0] sync;
  logic [2:0] prev;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  fsc_link_t  next_link;

  // ==========================================================================
  // Bit shifter; address bits are taken on rising link clock edges
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_shreg   = shreg;
    next_link    = '0;
    next_link.data = o_link.data;
    if (sync[1]) begin
      next_bit_cnt = 3'h0;
      if (!prev[1]) begin
        next_link.frame_end = 1'b1;
        next_link.aligned   = (bit_cnt == 3'h0);
      end
    end else if (sync[2] && !prev[2]) begin
      next_shreg   = {shreg[6:0], sync[0]};
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        next_link.byte_stb = 1'b1;
        next_link.data     = next_shreg;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta    <= PIN_IDLE;
      sync    <= PIN_IDLE;
      prev    <= PIN_IDLE;
      bit_cnt <= 3'h0;
      shreg   <= 8'h00;
      o_link  <= '0;
    end else if (i_ce) begin
      meta    <= {i_link_clk, i_cs_n, i_serial_io_lines};
      sync    <= meta;
      prev    <= sync;
      bit_cnt <= next_bit_cnt;
      shreg   <= next_shreg;
      o_link  <= next_link;
    end
  end

endmodule

// ### hw/fsc_ctrl.sv
// Erase, program start, suspend and resume sequencer of a serial NOR flash
`timescale 1ns/100ps
module fsc_ctrl
  import fsc_pkg::*;
#(
  parameter int unsigned T_SSE_US  = 1000,
  parameter int unsigned T_SE_US   = 10000,
  parameter int unsigned T_DIE_US  = 100000,
  parameter int unsigned T_PP_US   = 500,
  parameter int unsigned T_SUSP_US = 30
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_ce,
  input  wire logic              i_link_clk,
  input  wire logic              i_cs_n,
  input  wire logic              i_serial_io_lines,
  input  wire logic              i_addr_locked,
  input  wire logic              i_any_locked,
  input  wire logic              i_array_stall,
  input  wire logic              i_clear_flags,
  output logic                   o_wip,
  output logic                   o_wel,
  output logic [7:0]             o_flag_status,
  output logic                   o_array_erase,
  output logic                   o_array_prog,
  output logic                   o_array_die,
  output logic [ADDR_W-1:0]      o_array_addr,
  output logic [ADDR_W-1:0]      o_lock_addr,
  output logic                   o_read_guard,
  output logic [ADDR_W-1:SECT_LSB] o_read_guard_sect
);

  // ==========================================================================
  // Timing
  localparam int unsigned C_SSE  = us_to_cyc(T_SSE_US);
  localparam int unsigned C_SE   = us_to_cyc(T_SE_US);
  localparam int unsigned C_DIE  = us_to_cyc(T_DIE_US);
  localparam int unsigned C_PP   = us_to_cyc(T_PP_US);
  localparam int unsigned C_SUSP = us_to_cyc(T_SUSP_US);

  if (C_SSE == 0 || C_SE == 0 || C_DIE == 0 || C_PP == 0 || C_SUSP == 0 ||
      C_DIE > 32'h7fff_ffff / TIMEOUT_MULT) begin : g_bad_time
    $error("fsc_ctrl: operation times must be nonzero and fit the counters");
  end

  function automatic logic [31:0] dur_of(input fsc_kind_t k);
    case (k)
      K_SSE:   dur_of = C_SSE[31:0];
      K_SE:    dur_of = C_SE[31:0];
      K_DIE:   dur_of = C_DIE[31:0];
      default: dur_of = C_PP[31:0];
    endcase
  endfunction

  // ==========================================================================
  // States
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_SWT  = 3'b100
  } fsc_state_t;

  fsc_link_t         lk;
  fsc_state_t        st;
  fsc_state_t        next_st;
  logic [7:0]        opcode;
  logic [7:0]        next_opcode;
  logic [ADDR_W-1:0] next_addr;
  logic [2:0]        nbytes;
  logic [2:0]        next_nbytes;
  logic              next_wel;
  logic [7:0]        next_fsr;
  fsc_op_t           cur;
  fsc_op_t           next_cur;
  fsc_op_t           stack      [2];
  fsc_op_t           next_stack [2];
  logic [1:0]        depth;
  logic [1:0]        next_depth;
  logic [31:0]       elapsed;
  logic [31:0]       next_elapsed;
  logic [31:0]       lat;
  logic [31:0]       next_lat;
  logic              locked;
  logic              busy;

  fsc_link_rx u_rx (
    .i_ref_clk         (i_ref_clk),
    .i_resetn          (i_resetn),
    .i_ce              (i_ce),
    .i_link_clk        (i_link_clk),
    .i_cs_n            (i_cs_n),
    .i_serial_io_lines (i_serial_io_lines),
    .o_link            (lk)
  );

  // ==========================================================================
  // Command decode and sequencing
  always_comb begin
    next_st      = st;
    next_opcode  = opcode;
    next_addr    = o_lock_addr;
    next_nbytes  = nbytes;
    next_wel     = o_wel;
    next_fsr     = o_flag_status;
    next_cur     = cur;
    next_stack   = stack;
    next_depth   = depth;
    next_elapsed = elapsed;
    next_lat     = lat;
    locked       = 1'b0;
    busy         = (st != ST_IDLE);
    // Clear goes first so any flag set below in the same cycle wins
    if (i_clear_flags) begin
      next_fsr[FSR_PROT] = 1'b0;
      next_fsr[FSR_PERR] = 1'b0;
      next_fsr[FSR_EERR] = 1'b0;
    end
    if (lk.byte_stb) begin
      if (nbytes == 3'h0) begin
        next_opcode = lk.data;
      end else if (nbytes < CMD_BYTES) begin
        next_addr = {o_lock_addr[ADDR_W-9:0], lk.data};
      end
      if (nbytes != CMD_BYTES) begin
        next_nbytes = nbytes + 3'h1;
      end
    end
    // A frame counts only if it ends on a byte boundary after its last byte
    if (lk.frame_end) begin
      next_nbytes = 3'h0;
    end
    if (lk.frame_end && lk.aligned && !busy) begin
      if (opcode == OP_WREN && nbytes == OPC_BYTES) begin
        next_wel = 1'b1;
      end else if (opcode == OP_WRDI && nbytes == OPC_BYTES) begin
        next_wel = 1'b0;
      end else if ((opcode == OP_SSE || opcode == OP_SE || opcode == OP_DIE) &&
                   nbytes == CMD_BYTES && o_wel && depth == 2'h0) begin
        locked = (opcode == OP_DIE) ? i_any_locked : i_addr_locked;
        if (locked) begin
          next_fsr[FSR_PROT] = 1'b1;
          next_fsr[FSR_EERR] = 1'b1;
        end else begin
          next_cur.kind   = (opcode == OP_SSE) ? K_SSE : (opcode == OP_SE) ? K_SE : K_DIE;
          next_cur.addr   = o_lock_addr;
          next_cur.remain = dur_of(next_cur.kind);
          next_st         = ST_RUN;
        end
      end else if (opcode == OP_PROG && nbytes == CMD_BYTES && o_wel && !o_flag_status[FSR_PSUS]) begin
        if (depth != 2'h0 && stack[0].kind != K_PROG &&
            stack[0].addr[ADDR_W-1:SECT_LSB] == o_lock_addr[ADDR_W-1:SECT_LSB]) begin
          next_fsr[FSR_PERR] = 1'b1;
        end else if (i_addr_locked) begin
          next_fsr[FSR_PROT] = 1'b1;
          next_fsr[FSR_PERR] = 1'b1;
        end else begin
          next_cur.kind   = K_PROG;
          next_cur.addr   = o_lock_addr;
          next_cur.remain = dur_of(K_PROG);
          next_st         = ST_RUN;
        end
      end else if (opcode == OP_RESUME && nbytes == OPC_BYTES && depth != 2'h0) begin
        // No lock lookup on resume: the saved operation simply continues
        next_cur   = stack[depth[1]];
        next_depth = depth - 2'h1;
        next_st    = ST_RUN;
        if (stack[depth[1]].kind == K_PROG) begin
          next_fsr[FSR_PSUS] = 1'b0;
        end else begin
          next_fsr[FSR_ESUS] = 1'b0;
        end
      end
    end
    if (next_st == ST_RUN && st == ST_IDLE) begin
      next_fsr[FSR_RDY] = 1'b0;
      next_elapsed      = 32'h0;
    end
    if (busy) begin
      next_elapsed = elapsed + 32'h1;
      if (!i_array_stall && cur.remain != 32'h0) begin
        next_cur.remain = cur.remain - 32'h1;
      end
      if (cur.remain == 32'h0) begin
        next_st            = ST_IDLE;
        next_wel           = 1'b0;
        next_fsr[FSR_RDY]  = 1'b1;
        next_fsr[cur.kind == K_PROG ? FSR_PSUS : FSR_ESUS] = 1'b0;
      end else if (elapsed >= dur_of(cur.kind) * TIMEOUT_MULT) begin
        next_st            = ST_IDLE;
        next_wel           = 1'b0;
        next_fsr[FSR_RDY]  = 1'b1;
        next_fsr[cur.kind == K_PROG ? FSR_PERR : FSR_EERR] = 1'b1;
        next_fsr[cur.kind == K_PROG ? FSR_PSUS : FSR_ESUS] = 1'b0;
      end else if (st == ST_SWT) begin
        next_lat = lat - 32'h1;
        if (lat == 32'h1) begin
          next_stack[depth[0]] = next_cur;
          next_depth           = depth + 2'h1;
          next_st              = ST_IDLE;
          next_fsr[FSR_RDY]    = 1'b1;
        end
      end else if (lk.frame_end && lk.aligned && opcode == OP_SUSP &&
                   nbytes == OPC_BYTES && depth != MAX_DEPTH) begin
        next_fsr[cur.kind == K_PROG ? FSR_PSUS : FSR_ESUS] = 1'b1;
        next_lat = C_SUSP[31:0];
        next_st  = ST_SWT;
      end
    end
  end

  // ==========================================================================
  // State registers; reset drops any suspended work
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st                <= ST_IDLE;
      opcode            <= 8'h00;
      nbytes            <= 3'h0;
      o_wel             <= 1'b0;
      o_flag_status     <= FSR_RESET;
      cur               <= '0;
      stack[0]          <= '0;
      stack[1]          <= '0;
      depth             <= 2'h0;
      elapsed           <= 32'h0;
      lat               <= 32'h0;
      o_wip             <= 1'b0;
      o_array_erase     <= 1'b0;
      o_array_prog      <= 1'b0;
      o_array_die       <= 1'b0;
      o_array_addr      <= '0;
      o_lock_addr       <= '0;
      o_read_guard      <= 1'b0;
      o_read_guard_sect <= '0;
    end else if (i_ce) begin
      st                <= next_st;
      opcode            <= next_opcode;
      nbytes            <= next_nbytes;
      o_wel             <= next_wel;
      o_flag_status     <= next_fsr;
      cur               <= next_cur;
      stack             <= next_stack;
      depth             <= next_depth;
      elapsed           <= next_elapsed;
      lat               <= next_lat;
      o_wip             <= (next_st != ST_IDLE);
      // The array fills an erased region with ones only
      o_array_erase     <= (next_st != ST_IDLE) && next_cur.kind != K_PROG;
      o_array_prog      <= (next_st != ST_IDLE) && next_cur.kind == K_PROG;
      o_array_die       <= (next_st != ST_IDLE) && next_cur.kind == K_DIE;
      o_array_addr      <= next_cur.addr;
      o_lock_addr       <= next_addr;
      o_read_guard      <= (next_depth != 2'h0);
      o_read_guard_sect <= next_stack[next_depth[1]].addr[ADDR_W-1:SECT_LSB];
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_susp_req;
    $rose(o_flag_status[FSR_ESUS]) || $rose(o_flag_status[FSR_PSUS]);
  endsequence

  sequence s_susp_entered;
    $rose(o_flag_status[FSR_RDY]) && depth > $past(depth);
  endsequence

  a_busy_ready_pair: assert property (o_wip != o_flag_status[FSR_RDY])
    else $error("busy and ready disagree");
  a_start_needs_wel: assert property ($rose(o_wip) && depth == $past(depth) |-> $past(o_wel))
    else $error("operation started without write enable");
  a_done_clears_wel: assert property ($fell(o_wip) && depth == $past(depth) |-> !o_wel)
    else $error("write enable still set after completion");
  a_refuse_keeps_wel: assert property ($rose(o_flag_status[FSR_PROT]) |-> o_wel && !o_wip)
    else $error("protection refusal changed latch or started work");
  a_refuse_pair: assert property ($rose(o_flag_status[FSR_PROT]) |->
                                  o_flag_status[FSR_EERR] || o_flag_status[FSR_PERR])
    else $error("protection flag without error flag");
  a_timeout_err: assert property ($rose(o_flag_status[FSR_EERR]) && !o_flag_status[FSR_PROT] |->
                                  !o_wel && !o_wip)
    else $error("erase timeout left latch or busy set");
  a_susp_latency: assert property (s_susp_req |-> !o_flag_status[FSR_RDY] ##1 o_wip)
    else $error("suspended flag set without latency");
  a_susp_entry: assert property (s_susp_entered |->
                                 (o_flag_status[FSR_ESUS] || o_flag_status[FSR_PSUS]) && !o_wip)
    else $error("suspend entered without its flag");
  a_depth_max: assert property (depth <= MAX_DEPTH)
    else $error("suspend stack overflow");
  a_resume_busy: assert property (depth < $past(depth) |-> o_wip && !o_flag_status[FSR_RDY])
    else $error("resume did not restart operation");
  a_guard_valid: assert property (!o_wip |-> o_read_guard ==
                                  (o_flag_status[FSR_ESUS] || o_flag_status[FSR_PSUS]))
    else $error("read guard out of step with stack");

endmodule

// ### testbench/fsc_host_model.sv
// Host controller model that frames commands on the serial link
`timescale 1ns/100ps
module fsc_host_model (
  output logic o_link_clk,
  output logic o_cs_n,
  output logic o_io
);
  // ====================
  // Idle levels and timing
  // Half period is settable so the bench can run a slow host as well as a prompt one
  int half = 32;

  initial begin
    o_link_clk = 1'b0;
    o_cs_n     = 1'b1;
    o_io       = 1'b0;
  end

  // ====================
  // Frame: select, shift MSB first on rising edges, deselect
  // Clock stays low outside frames; released data line shows the inverse of its last bit
  task automatic send(input logic [39:0] bits, input int n);
    #1.3;
    o_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_io = bits[39-i];
      #half o_link_clk = 1'b1;
      #half o_link_clk = 1'b0;
    end
    #half o_cs_n = 1'b1;
    o_io = ~o_io;
  endtask
endmodule

// ### testbench/fsc_ctrl_tb.sv
// Self-checking bench for the erase and suspend sequencer
`timescale 1ns/100ps
module fsc_ctrl_tb
  import fsc_pkg::*;
;
  // ====================
  // Signals
  localparam int D_SUB  = 2 * CLK_MHZ;
  localparam int D_DIE  = 3 * CLK_MHZ;
  localparam int D_SUSP = CLK_MHZ;
  localparam int CEIL   = 40000;

  logic                    i_ref_clk, i_resetn, i_ce;
  logic                    i_addr_locked, i_any_locked, i_array_stall, i_clear_flags;
  logic                    link_clk, cs_n, sio;
  logic                    o_wip, o_wel, o_array_erase, o_array_prog, o_array_die, o_read_guard;
  logic [7:0]              o_flag_status;
  logic [ADDR_W-1:0]       o_array_addr, o_lock_addr;
  logic [ADDR_W-1:SECT_LSB] o_read_guard_sect;
  int                      error_cnt, n_checks;
  int                      cyc_cnt = 0;
  logic [7:0]              ops [3] = '{OP_SSE, OP_SE, OP_DIE};
  int                      durs [3] = '{D_SUB, D_SUB, D_DIE};

  // ====================
  // Clock, instances and hang guard
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  // Short operation times keep the run small; suspend latency stays below every op time
  fsc_ctrl #(.T_SSE_US(2), .T_SE_US(2), .T_DIE_US(3), .T_PP_US(2), .T_SUSP_US(1)) dut_u (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_link_clk(link_clk),
    .i_cs_n(cs_n), .i_serial_io_lines(sio), .i_addr_locked(i_addr_locked),
    .i_any_locked(i_any_locked), .i_array_stall(i_array_stall), .i_clear_flags(i_clear_flags),
    .o_wip(o_wip), .o_wel(o_wel), .o_flag_status(o_flag_status), .o_array_erase(o_array_erase),
    .o_array_prog(o_array_prog), .o_array_die(o_array_die), .o_array_addr(o_array_addr),
    .o_lock_addr(o_lock_addr), .o_read_guard(o_read_guard), .o_read_guard_sect(o_read_guard_sect));

  fsc_host_model host_u (.o_link_clk(link_clk), .o_cs_n(cs_n), .o_io(sio));

  always @(posedge i_ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == CEIL) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ====================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Order: addr lock, any lock, stall, clear flags
  task automatic drv(input logic [3:0] v);
    @(posedge i_ref_clk);
    {i_addr_locked, i_any_locked, i_array_stall, i_clear_flags} <= v;
  endtask

  task automatic clr();
    drv(4'h1);
    drv(4'h0);
    cyc(2);
  endtask

  // Answer lands about four cycles after deselect, so ten cycles settle it
  task automatic cmd(input logic [7:0] op);
    host_u.send({op, 32'h0}, 8);
    cyc(10);
  endtask

  task automatic cmda(input logic [7:0] op, input logic [23:0] a, input int extra);
    host_u.send({op, a, 8'ha5}, 32 + extra);
    cyc(10);
  endtask

  task automatic wait_idle(output int k);
    k = 0;
    while (!(o_wip === 1'b0 && o_flag_status[FSR_RDY] === 1'b1) && k < 2000) begin
      cyc(1);
      k++;
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ====================
  // Scenarios
  initial begin
    int k;
    {i_resetn, i_addr_locked, i_any_locked, i_array_stall, i_clear_flags} = '0;
    i_ce = 1'b1;
    error_cnt = 0;
    n_checks = 0;
    repeat (20) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    cyc(2);
    chk("fsr", 8'h80, o_flag_status);
    chk("wel", 0, o_wel);
    cmda(OP_SSE, 24'h012345, 0);
    chk("laddr", 24'h012345, o_lock_addr);
    chk("wip", 0, o_wip);
    chk("fsr", 8'h80, o_flag_status);
    cmd(OP_WREN);
    chk("wel", 1, o_wel);
    cmda(OP_SSE, 24'h012345, 3);
    chk("wip", 0, o_wip);
    chk("wel", 1, o_wel);
    chk("fsr", 8'h80, o_flag_status);
    drv(4'h8);
    cmda(OP_SSE, 24'h012345, 0);
    chk("fsr", 8'ha2, o_flag_status);
    chk("wel", 1, o_wel);
    clr();
    drv(4'h4);
    cmda(OP_DIE, 24'h000000, 0);
    chk("fsr", 8'ha2, o_flag_status);
    chk("wel", 1, o_wel);
    clr();
    for (int i = 0; i < 3; i++) begin
      cmd(OP_WREN);
      cmda(ops[i], 24'h034567, 0);
      chk("wip", 1, o_wip);
      chk("rdy", 0, o_flag_status[FSR_RDY]);
      chk("run", 1, (i == 2) ? o_array_die : o_array_erase);
      chk("prog", 0, o_array_prog);
      chk("sect", 8'h03, o_array_addr[23:16]);
      wait_idle(k);
      chk("dur", 1, k > durs[i] - 16 && k <= durs[i]);
      chk("wel", 0, o_wel);
      chk("fsr", 8'h80, o_flag_status);
    end
    cmd(OP_WREN);
    cmda(OP_SSE, 24'h050000, 0);
    cmd(OP_SUSP);
    chk("esus", 1, o_flag_status[FSR_ESUS]);
    chk("rdy", 0, o_flag_status[FSR_RDY]);
    wait_idle(k);
    chk("lat", 1, k > D_SUSP - 16 && k <= D_SUSP);
    chk("guard", 1, o_read_guard);
    chk("gsect", 8'h05, o_read_guard_sect);
    cmd(OP_WREN);
    cmda(OP_PROG, 24'h051000, 8);
    chk("perr", 1, o_flag_status[FSR_PERR]);
    chk("wel", 1, o_wel);
    chk("prog", 0, o_array_prog);
    clr();
    cmda(OP_PROG, 24'h070000, 8);
    chk("prog", 1, o_array_prog);
    cmd(OP_SUSP);
    chk("psus", 1, o_flag_status[FSR_PSUS]);
    wait_idle(k);
    cmd(OP_SUSP);
    chk("fsr", 8'hc4, o_flag_status);
    chk("gsect", 8'h07, o_read_guard_sect);
    cmd(OP_RESUME);
    chk("wip", 1, o_wip);
    chk("rdy", 0, o_flag_status[FSR_RDY]);
    chk("psus", 0, o_flag_status[FSR_PSUS]);
    chk("esus", 1, o_flag_status[FSR_ESUS]);
    wait_idle(k);
    drv(4'h8);
    cmd(OP_RESUME);
    chk("erase", 1, o_array_erase);
    chk("esus", 0, o_flag_status[FSR_ESUS]);
    wait_idle(k);
    chk("fsr", 8'h80, o_flag_status);
    chk("guard", 0, o_read_guard);
    drv(4'h0);
    cmd(OP_RESUME);
    chk("wip", 0, o_wip);
    chk("fsr", 8'h80, o_flag_status);
    cmd(OP_WREN);
    cmda(OP_SE, 24'h020000, 0);
    cyc(230);
    cmd(OP_SUSP);
    wait_idle(k);
    chk("fsr", 8'h80, o_flag_status);
    chk("guard", 0, o_read_guard);
    drv(4'h2);
    cmd(OP_WREN);
    cmda(OP_SSE, 24'h010000, 0);
    wait_idle(k);
    chk("tmo", 1, k > 2 * D_SUB - 16 && k <= 2 * D_SUB);
    chk("eerr", 1, o_flag_status[FSR_EERR]);
    chk("wel", 0, o_wel);
    drv(4'h0);
    clr();
    cmd(OP_WREN);
    cmda(OP_SSE, 24'h050000, 0);
    cmd(OP_SUSP);
    wait_idle(k);
    @(posedge i_ref_clk);
    i_resetn <= 1'b0;
    cyc(2);
    chk("fsr", 8'h80, o_flag_status);
    chk("guard", 0, o_read_guard);
    @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    cyc(2);
    cmd(OP_RESUME);
    chk("wip", 0, o_wip);
    report_and_stop();
  end
endmodule
